// [verilog/srp_pkg.sv]
package srp_pkg;
    // command word layout, first bit shifted in sits at the top
    localparam int WORD_W = 15;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int CE_W = 2;
    localparam int DATA_LSB = 0;
    localparam int ADDR_LSB = 8;
    localparam int CE_LSB = 12;
    localparam int RW_BIT = 14;
    localparam logic RW_WRITE = 1'h0;
    localparam logic RW_READ = 1'h1;
    localparam int NUM_REGS = 16;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam logic [CE_W-1:0] CE_DEFAULT = 2'h0;

    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int T_POR_NS = 270;
    localparam int POR_CYC = T_POR_NS / CLK_PERIOD_NS;
    localparam int T_SCLK_MIN_NS = 36;
    localparam int SCLK_HALF_CYC = (T_SCLK_MIN_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_SENSC_NS = 10;
    localparam int LEAD_CYC = (T_SENSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_SCSEN_NS = 5;
    localparam int TAIL_CYC = (T_SCSEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_SENW_MCLK = 2;
    // master clock periods plus the device's strobe synchroniser and commit cycle
    localparam int GAP_CYC = T_SENW_MCLK + 3;
    localparam int CNT_W = 6;
    localparam int BIT_CNT_W = 4;

    typedef enum logic [2:0] {
        ST_POR,
        ST_IDLE,
        ST_LEAD,
        ST_SHIFT,
        ST_TAIL,
        ST_GAP
    } srp_host_state_t;
endpackage

// [verilog/srp_link_if.sv]
`timescale 1ns/1ps
interface srp_link_if;
    logic frame_strobe_n;
    logic sclk;
    logic sdi;
    logic sdo;

    modport dev (
        input frame_strobe_n,
        input sclk,
        input sdi,
        output sdo
    );

    modport host (
        output frame_strobe_n,
        output sclk,
        output sdi,
        input sdo
    );
endinterface

// [verilog/srp_device.sv]
`timescale 1ns/1ps
// Operation
// - shift input bit each rising clock while low
// - keep only last fifteen bits until high
// - word: data, address, chip-enable, direction
// - host sends direction low for writes
// - strobe rise loads data into addressed register when chip-enable matches
// - host sends direction high for reads
// - read ignores data bits, registers unchanged
// - next frame shifts out previously addressed register
// - read-back goes out most significant first
// - master clock runs, strobe high two periods
// - host shifts fifteen periods before closing
// - settling finishes within 270 ns after reset
module srp_device #(
    parameter logic [srp_pkg::CE_W-1:0] CE_MATCH = srp_pkg::CE_DEFAULT,
    parameter int POR_CYC = srp_pkg::POR_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    srp_link_if.dev link,
    output logic o_settled,
    output logic [srp_pkg::NUM_REGS*srp_pkg::DATA_W-1:0] o_regs,
    output logic o_wr_stb,
    output logic [srp_pkg::ADDR_W-1:0] o_wr_addr,
    output logic [srp_pkg::DATA_W-1:0] o_wr_data
);

    // link domain: runs on the shift clock, which stands still between
    // frames, so nothing here depends on an edge outside a frame

    logic [srp_pkg::WORD_W-1:0] shift_ff;
    logic [srp_pkg::WORD_W-1:0] nxt_shift;
    logic [srp_pkg::BIT_CNT_W-1:0] out_cnt_ff;
    logic [srp_pkg::BIT_CNT_W-1:0] nxt_out_cnt;
    logic seen_ff;
    logic nxt_seen;
    logic new_frame;

    // system domain signals read by the link domain
    logic seq_ff;
    logic [srp_pkg::ADDR_W-1:0] rb_addr_ff;
    logic [srp_pkg::DATA_W-1:0] regs_ff [srp_pkg::NUM_REGS];

    // seq_ff only toggles while the strobe is high and the shift clock is
    // stopped, so it is steady at every link edge that reads it
    assign new_frame = (seen_ff != seq_ff);

    always_comb begin
        nxt_shift = shift_ff;
        nxt_out_cnt = out_cnt_ff;
        nxt_seen = seen_ff;
        if (!link.frame_strobe_n) begin
            // older bits fall off the top, the newest fifteen remain
            nxt_shift = {shift_ff[srp_pkg::WORD_W-2:0], link.sdi};
            if (new_frame) begin
                nxt_out_cnt = srp_pkg::BIT_CNT_W'(1);
                nxt_seen = seq_ff;
            end else if (out_cnt_ff != '1) begin
                nxt_out_cnt = out_cnt_ff + srp_pkg::BIT_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge link.sclk or posedge i_rst) begin
        if (i_rst) begin
            shift_ff <= '0;
            out_cnt_ff <= '0;
            seen_ff <= 1'h1;
        end else begin
            shift_ff <= nxt_shift;
            out_cnt_ff <= nxt_out_cnt;
            seen_ff <= nxt_seen;
        end
    end

    // serial output: bit index zero is ready as soon as the strobe falls,
    // before any shift clock edge; later bits change after each rising edge
    logic [srp_pkg::BIT_CNT_W-1:0] out_idx;
    logic [srp_pkg::DATA_W-1:0] rb_word;

    always_comb begin
        out_idx = new_frame ? '0 : out_cnt_ff;
        rb_word = regs_ff[rb_addr_ff];
        if (out_idx < srp_pkg::BIT_CNT_W'(srp_pkg::DATA_W)) begin
            link.sdo = rb_word[srp_pkg::DATA_W - 1 - 32'(out_idx)];
        end else begin
            // past the eighth bit the line idles low
            link.sdo = 1'h0;
        end
    end

    // system domain: the master clock, which keeps running during frames

    logic stb_s1_ff;
    logic stb_s2_ff;
    logic stb_s3_ff;
    logic strobe_rise;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            stb_s1_ff <= 1'h1;
            stb_s2_ff <= 1'h1;
            stb_s3_ff <= 1'h1;
        end else begin
            stb_s1_ff <= link.frame_strobe_n;
            stb_s2_ff <= stb_s1_ff;
            stb_s3_ff <= stb_s2_ff;
        end
    end

    assign strobe_rise = stb_s2_ff && !stb_s3_ff;

    // settling counter after reset
    logic [srp_pkg::CNT_W-1:0] por_cnt_ff;
    logic [srp_pkg::CNT_W-1:0] nxt_por_cnt;
    logic settled_ff;
    logic nxt_settled;

    always_comb begin
        nxt_por_cnt = por_cnt_ff;
        nxt_settled = settled_ff;
        if (!settled_ff) begin
            if (por_cnt_ff == srp_pkg::CNT_W'(POR_CYC - 1)) begin
                nxt_settled = 1'h1;
            end else begin
                nxt_por_cnt = por_cnt_ff + srp_pkg::CNT_W'(1);
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            por_cnt_ff <= '0;
            settled_ff <= 1'h0;
        end else begin
            por_cnt_ff <= nxt_por_cnt;
            settled_ff <= nxt_settled;
        end
    end

    // command decode; shift_ff is frozen while the strobe is high, the link
    // host keeps the strobe high long enough for this copy to be taken
    logic cmd_rw;
    logic [srp_pkg::CE_W-1:0] cmd_ce;
    logic [srp_pkg::ADDR_W-1:0] cmd_addr;
    logic [srp_pkg::DATA_W-1:0] cmd_data;
    logic cmd_write;

    always_comb begin
        cmd_rw = shift_ff[srp_pkg::RW_BIT];
        cmd_ce = shift_ff[srp_pkg::CE_LSB +: srp_pkg::CE_W];
        cmd_addr = shift_ff[srp_pkg::ADDR_LSB +: srp_pkg::ADDR_W];
        cmd_data = shift_ff[srp_pkg::DATA_LSB +: srp_pkg::DATA_W];
        // a frame on another chip-enable leaves our registers alone
        cmd_write = strobe_rise && settled_ff && (cmd_rw == srp_pkg::RW_WRITE)
            && (cmd_ce == CE_MATCH);
    end

    logic [srp_pkg::DATA_W-1:0] nxt_regs [srp_pkg::NUM_REGS];
    logic nxt_seq;
    logic [srp_pkg::ADDR_W-1:0] nxt_rb_addr;
    logic wr_stb_ff;
    logic nxt_wr_stb;
    logic [srp_pkg::ADDR_W-1:0] wr_addr_ff;
    logic [srp_pkg::ADDR_W-1:0] nxt_wr_addr;
    logic [srp_pkg::DATA_W-1:0] wr_data_ff;
    logic [srp_pkg::DATA_W-1:0] nxt_wr_data;

    always_comb begin
        nxt_seq = seq_ff;
        nxt_rb_addr = rb_addr_ff;
        nxt_wr_stb = 1'h0;
        nxt_wr_addr = wr_addr_ff;
        nxt_wr_data = wr_data_ff;
        if (strobe_rise) begin
            // the next frame reads back this address, read or write alike
            nxt_seq = ~seq_ff;
            nxt_rb_addr = cmd_addr;
        end
        if (cmd_write) begin
            nxt_wr_stb = 1'h1;
            nxt_wr_addr = cmd_addr;
            nxt_wr_data = cmd_data;
        end
        // reads fall through here and never touch the register array
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            seq_ff <= 1'h0;
            rb_addr_ff <= '0;
            wr_stb_ff <= 1'h0;
            wr_addr_ff <= '0;
            wr_data_ff <= '0;
        end else begin
            seq_ff <= nxt_seq;
            rb_addr_ff <= nxt_rb_addr;
            wr_stb_ff <= nxt_wr_stb;
            wr_addr_ff <= nxt_wr_addr;
            wr_data_ff <= nxt_wr_data;
        end
    end

    // register array, one entry per address
    generate
        for (genvar gi = 0; gi < srp_pkg::NUM_REGS; gi++) begin : g_reg
            always_comb begin
                nxt_regs[gi] = regs_ff[gi];
                if (cmd_write && (cmd_addr == srp_pkg::ADDR_W'(gi))) begin
                    nxt_regs[gi] = cmd_data;
                end
            end

            always_ff @(posedge i_sys_clk or posedge i_rst) begin
                if (i_rst) begin
                    regs_ff[gi] <= srp_pkg::REG_RESET;
                end else begin
                    regs_ff[gi] <= nxt_regs[gi];
                end
            end

            assign o_regs[gi*srp_pkg::DATA_W +: srp_pkg::DATA_W] = regs_ff[gi];
        end
    endgenerate

    assign o_settled = settled_ff;
    assign o_wr_stb = wr_stb_ff;
    assign o_wr_addr = wr_addr_ff;
    assign o_wr_data = wr_data_ff;

endmodule

// [verilog/srp_host.sv]
`timescale 1ns/1ps
module srp_host #(
    parameter int POR_CYC = srp_pkg::POR_CYC,
    parameter int HALF_CYC = srp_pkg::SCLK_HALF_CYC,
    parameter int GAP_CYC = srp_pkg::GAP_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    srp_link_if.host link,
    input wire logic i_req,
    input wire logic i_rw,
    input wire logic [srp_pkg::CE_W-1:0] i_ce,
    input wire logic [srp_pkg::ADDR_W-1:0] i_addr,
    input wire logic [srp_pkg::DATA_W-1:0] i_data,
    output logic o_ready,
    output logic o_done,
    output logic [srp_pkg::DATA_W-1:0] o_rd_data
);

    logic sdo_s1_ff;
    logic sdo_s2_ff;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sdo_s1_ff <= 1'h0;
            sdo_s2_ff <= 1'h0;
        end else begin
            sdo_s1_ff <= link.sdo;
            sdo_s2_ff <= sdo_s1_ff;
        end
    end

    srp_pkg::srp_host_state_t st_ff, nxt_st;
    logic [srp_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [srp_pkg::BIT_CNT_W-1:0] bit_ff, nxt_bit;
    logic [srp_pkg::WORD_W-1:0] word_ff, nxt_word;
    logic [srp_pkg::DATA_W-1:0] rx_ff, nxt_rx;
    logic strobe_n_ff, nxt_strobe_n;
    logic sclk_ff, nxt_sclk;
    logic sdi_ff, nxt_sdi;
    logic done_ff, nxt_done;

    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff + srp_pkg::CNT_W'(1);
        nxt_bit = bit_ff;
        nxt_word = word_ff;
        nxt_rx = rx_ff;
        nxt_strobe_n = strobe_n_ff;
        nxt_sclk = sclk_ff;
        nxt_sdi = sdi_ff;
        nxt_done = 1'h0;
        unique case (st_ff)
            srp_pkg::ST_POR: begin
                // no access until the device has settled
                if (cnt_ff == srp_pkg::CNT_W'(POR_CYC)) begin
                    nxt_st = srp_pkg::ST_IDLE;
                end
            end
            srp_pkg::ST_IDLE: begin
                nxt_cnt = '0;
                if (i_req) begin
                    nxt_word = {i_rw, i_ce, i_addr, i_data};
                    nxt_strobe_n = 1'h0;
                    nxt_st = srp_pkg::ST_LEAD;
                end
            end
            srp_pkg::ST_LEAD: begin
                if (cnt_ff == srp_pkg::CNT_W'(srp_pkg::LEAD_CYC - 1)) begin
                    nxt_cnt = '0;
                    nxt_bit = '0;
                    nxt_sdi = word_ff[srp_pkg::WORD_W-1];
                    nxt_st = srp_pkg::ST_SHIFT;
                end
            end
            srp_pkg::ST_SHIFT: begin
                if (cnt_ff == srp_pkg::CNT_W'(HALF_CYC - 1)) begin
                    nxt_cnt = '0;
                    if (!sclk_ff) begin
                        nxt_sclk = 1'h1;
                        // sample before the device moves to its next bit
                        if (bit_ff < srp_pkg::BIT_CNT_W'(srp_pkg::DATA_W)) begin
                            nxt_rx = {rx_ff[srp_pkg::DATA_W-2:0], sdo_s2_ff};
                        end
                    end else begin
                        nxt_sclk = 1'h0;
                        nxt_bit = bit_ff + srp_pkg::BIT_CNT_W'(1);
                        nxt_word = {word_ff[srp_pkg::WORD_W-2:0], 1'h0};
                        nxt_sdi = word_ff[srp_pkg::WORD_W-2];
                        // all fifteen periods shifted before closing
                        if (bit_ff == srp_pkg::BIT_CNT_W'(srp_pkg::WORD_W - 1)) begin
                            nxt_st = srp_pkg::ST_TAIL;
                        end
                    end
                end
            end
            srp_pkg::ST_TAIL: begin
                if (cnt_ff == srp_pkg::CNT_W'(srp_pkg::TAIL_CYC - 1)) begin
                    nxt_cnt = '0;
                    nxt_strobe_n = 1'h1;
                    nxt_st = srp_pkg::ST_GAP;
                end
            end
            srp_pkg::ST_GAP: begin
                if (cnt_ff == srp_pkg::CNT_W'(GAP_CYC - 1)) begin
                    nxt_done = 1'h1;
                    nxt_st = srp_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= srp_pkg::ST_POR;
            cnt_ff <= '0;
            bit_ff <= '0;
            word_ff <= '0;
            rx_ff <= '0;
            strobe_n_ff <= 1'h1;
            sclk_ff <= 1'h0;
            sdi_ff <= 1'h0;
            done_ff <= 1'h0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            bit_ff <= nxt_bit;
            word_ff <= nxt_word;
            rx_ff <= nxt_rx;
            strobe_n_ff <= nxt_strobe_n;
            sclk_ff <= nxt_sclk;
            sdi_ff <= nxt_sdi;
            done_ff <= nxt_done;
        end
    end

    assign link.frame_strobe_n = strobe_n_ff;
    assign link.sclk = sclk_ff;
    assign link.sdi = sdi_ff;
    assign o_ready = (st_ff == srp_pkg::ST_IDLE);
    assign o_done = done_ff;
    assign o_rd_data = rx_ff;

endmodule

// [testbench/srp_link_sva.sv]
`timescale 1ns/1ps
module srp_link_sva #(
    parameter int POR_CYC = srp_pkg::POR_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic frame_strobe_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo
);
    logic sclk_ff, strb_ff, rise, fall, exp_bit;
    logic [4:0] cnt_ff;
    logic [14:0] word_ff;
    logic [3:0] prev_ff;
    logic [7:0] shadow_ff [16];
    int por_ff;

    // shift clock is slow against the system clock, so edges are seen by sampling
    assign rise = sclk & !sclk_ff;
    assign fall = !sclk & sclk_ff;
    assign exp_bit = shadow_ff[prev_ff][3'h7 - cnt_ff[2:0]];

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sclk_ff <= 1'h0;
            strb_ff <= 1'h1;
            cnt_ff <= 5'h00;
            word_ff <= 15'h0000;
            prev_ff <= 4'h0;
            por_ff <= 0;
            for (int i = 0; i < 16; i++) begin
                shadow_ff[i] <= 8'h00;
            end
        end else begin
            sclk_ff <= sclk;
            strb_ff <= frame_strobe_n;
            if (por_ff <= POR_CYC) begin
                por_ff <= por_ff + 1;
            end
            if (frame_strobe_n) begin
                cnt_ff <= 5'h00;
            end else if (rise) begin
                cnt_ff <= cnt_ff + 5'h01;
                word_ff <= {word_ff[13:0], sdi};
            end
            if (frame_strobe_n && !strb_ff) begin
                prev_ff <= word_ff[11:8];
                // shadow follows only writes to the default chip-enable
                if (word_ff[14] == 1'h0 && word_ff[13:12] == 2'h0) begin
                    shadow_ff[word_ff[11:8]] <= word_ff[7:0];
                end
            end
        end
    end

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    chk_sclk_idle: assert property (frame_strobe_n |-> !sclk)
        else $error("shift clock runs outside a frame");
    chk_gap_width: assert property ($rose(frame_strobe_n) |-> frame_strobe_n [*5])
        else $error("strobe high time too short");
    chk_bit_count: assert property ($rose(frame_strobe_n) |-> cnt_ff == 5'h0f)
        else $error("frame closed without fifteen shift clocks");
    chk_sdi_setup: assert property (rise |-> $stable(sdi))
        else $error("serial input moved at shift clock rise");
    chk_lead_time: assert property ($fell(frame_strobe_n) |-> !sclk [*3])
        else $error("shift clock started too soon after strobe fall");
    chk_sdo_first: assert property ($fell(frame_strobe_n) |=> sdo == shadow_ff[prev_ff][7])
        else $error("first read-back bit wrong");
    chk_sdo_order: assert property (fall && cnt_ff inside {[1:7]} |-> sdo == exp_bit)
        else $error("read-back bit order wrong");
    chk_settle_wait: assert property (!frame_strobe_n |-> por_ff > POR_CYC)
        else $error("frame started before settling");

    cov_write: cover property ($rose(frame_strobe_n) && word_ff[14] == 1'h0);
    cov_read: cover property ($rose(frame_strobe_n) && word_ff[14] == 1'h1);
    cov_ce_off: cover property ($rose(frame_strobe_n) && word_ff[13:12] != 2'h0);
endmodule

// [testbench/test_serial_register_port.sv]
`timescale 1ns/1ps
module test_serial_register_port;
    localparam int POR = 4;
    logic i_sys_clk, i_rst, i_req, i_rw, o_ready, o_done, o_settled, o_wr_stb;
    logic [1:0] i_ce;
    logic [3:0] i_addr, o_wr_addr, stb_addr;
    logic [7:0] i_data, o_rd_data, o_wr_data, rd, stb_data;
    logic [127:0] o_regs, regs_b;
    int error_cnt = 0;
    int checked = 0;
    int stb_cnt = 0;

    srp_link_if link ();
    srp_link_if link_b ();

    srp_device #(.POR_CYC(POR)) i_srp_device (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .link(link.dev), .o_settled(o_settled), .o_regs(o_regs), .o_wr_stb(o_wr_stb),
        .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data));
    srp_host #(.POR_CYC(POR)) i_srp_host (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .link(link.host), .i_req(i_req), .i_rw(i_rw), .i_ce(i_ce), .i_addr(i_addr),
        .i_data(i_data), .o_ready(o_ready), .o_done(o_done), .o_rd_data(o_rd_data));
    // second device is driven by the bench to send frames the host never makes
    srp_device #(.POR_CYC(POR)) i_srp_device_b (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .link(link_b.dev), .o_settled(), .o_regs(regs_b), .o_wr_stb(), .o_wr_addr(),
        .o_wr_data());
    srp_link_sva #(.POR_CYC(POR)) i_srp_link_sva (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .frame_strobe_n(link.frame_strobe_n), .sclk(link.sclk), .sdi(link.sdi),
        .sdo(link.sdo));

    initial begin
        i_sys_clk = 1'h0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end

    always @(posedge i_sys_clk) begin
        if (o_wr_stb === 1'h1) begin
            stb_cnt <= stb_cnt + 1;
            stb_addr <= o_wr_addr;
            stb_data <= o_wr_data;
        end
    end

    function automatic logic [7:0] pat(input int a);
        return {4'(a), ~4'(a)};
    endfunction

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic fail(input string m);
        error_cnt++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            fail($sformatf("%s got %h exp %h", m, got, exp));
        end
    endtask

    task automatic xfer(input logic rw, input logic [1:0] ce, input int a, input logic [7:0] d);
        int n;
        n = 0;
        do begin
            @(negedge i_sys_clk);
            n++;
        end while (o_ready !== 1'h1 && n < 300);
        if (n >= 300) begin
            fail("host never ready");
            finish_test();
        end
        @(posedge i_sys_clk);
        i_req <= 1'h1;
        i_rw <= rw;
        i_ce <= ce;
        i_addr <= 4'(a);
        i_data <= d;
        @(posedge i_sys_clk);
        i_req <= 1'h0;
        n = 0;
        do begin
            @(negedge i_sys_clk);
            n++;
        end while (o_done !== 1'h1 && n < 300);
        if (n >= 300) begin
            fail("frame never done");
            finish_test();
        end
        rd = o_rd_data;
    endtask

    task automatic test_reset;
        i_rst <= 1'h1;
        repeat (5) @(posedge i_sys_clk);
        i_rst <= 1'h0;
        @(negedge i_sys_clk);
        cmp({7'h00, o_regs !== 128'h0}, 8'h00, "regs after reset");
        // the device settles on the por-th edge after release
        repeat (POR - 1) @(negedge i_sys_clk);
        cmp({7'h00, o_settled}, 8'h00, "settled early");
        @(negedge i_sys_clk);
        cmp({7'h00, o_settled}, 8'h01, "settled late");
        $display("test reset done");
    endtask

    task automatic test_write_read;
        int s;
        s = stb_cnt;
        xfer(1'h0, 2'h0, 3, 8'ha5);
        cmp(o_regs[31:24], 8'ha5, "write reg3");
        cmp(8'(stb_cnt - s), 8'h01, "write strobe count");
        cmp({stb_addr, 4'h0}, 8'h30, "strobe address");
        cmp(stb_data, 8'ha5, "strobe data");
        xfer(1'h1, 2'h0, 3, 8'hff);
        cmp(rd, 8'ha5, "read after write");
        cmp(o_regs[31:24], 8'ha5, "read leaves reg");
        xfer(1'h1, 2'h0, 3, 8'h00);
        cmp(rd, 8'ha5, "read after read");
        $display("test write_read done");
    endtask

    task automatic test_sweep;
        for (int a = 0; a < 16; a++) begin
            xfer(1'h0, 2'h0, a, pat(a));
            cmp(o_regs[8*a +: 8], pat(a), "sweep write");
            if (a > 0) begin
                cmp(rd, pat(a - 1), "sweep read-back");
            end
        end
        xfer(1'h1, 2'h0, 15, 8'h00);
        cmp(rd, pat(15), "last read-back");
        $display("test sweep done");
    endtask

    task automatic test_ce_read;
        int s;
        s = stb_cnt;
        for (int c = 1; c < 4; c++) begin
            xfer(1'h0, 2'(c), 7, 8'h3c);
            cmp(o_regs[63:56], pat(7), "foreign chip-enable");
        end
        cmp(8'(stb_cnt - s), 8'h00, "no write strobe");
        xfer(1'h1, 2'h2, 9, 8'h96);
        cmp(rd, pat(7), "address kept on refused write");
        cmp(o_regs[79:72], pat(9), "read data ignored");
        $display("test ce_read done");
    endtask

    task automatic test_long_frame;
        logic [19:0] w;
        // leading ones would make a read if they were kept
        w = {5'h1f, 1'h0, 2'h0, 4'h5, 8'hc3};
        link_b.frame_strobe_n = 1'h0;
        #20;
        for (int i = 19; i >= 0; i--) begin
            link_b.sdi = w[i];
            #15 link_b.sclk = 1'h1;
            #15 link_b.sclk = 1'h0;
        end
        #10 link_b.frame_strobe_n = 1'h1;
        link_b.sdi = ~w[0];
        repeat (10) @(negedge i_sys_clk);
        cmp(regs_b[47:40], 8'hc3, "long frame");
        $display("test long_frame done");
    endtask

    initial begin
        i_rst = 1'h1;
        i_req = 1'h0;
        i_rw = 1'h0;
        i_ce = 2'h0;
        i_addr = 4'h0;
        i_data = 8'h00;
        link_b.frame_strobe_n = 1'h1;
        link_b.sclk = 1'h0;
        link_b.sdi = 1'h0;
        test_reset();
        test_write_read();
        test_sweep();
        test_ce_read();
        test_long_frame();
        test_reset();
        xfer(1'h0, 2'h0, 3, 8'h5a);
        xfer(1'h1, 2'h0, 3, 8'h00);
        cmp(rd, 8'h5a, "works after second reset");
        finish_test();
    end
endmodule
